/* File: hdl/sdio_pkg.sv */
// constants, register map and state types of the strobed digital i/o block
`default_nettype none
package sdio_pkg;

    localparam int          DATA_W         = 8;
    localparam int          ADDR_W         = 3;
    localparam int          STAT_W         = 2;
    localparam int          SYNC_W         = 12;

    localparam logic [2:0]  ADDR_DOUT      = 3'h0;
    localparam logic [2:0]  ADDR_DIN       = 3'h1;
    localparam logic [2:0]  ADDR_CTRL      = 3'h2;
    localparam logic [2:0]  ADDR_STAT      = 3'h3;
    localparam logic [2:0]  ADDR_MASK      = 3'h4;
    localparam logic [2:0]  ADDR_PINS      = 3'h5;

    localparam int          CTRL_POL_BIT   = 0;
    localparam int          CTRL_EN_BIT    = 1;
    localparam int          STAT_USER_BIT  = 0;
    localparam int          STAT_LATCH_BIT = 1;

    localparam logic [7:0]  DOUT_RST       = 8'h00;
    localparam logic        POL_RST        = 1'h0;
    localparam logic        EN_RST         = 1'h1;
    localparam logic [1:0]  STAT_RST       = 2'h0;
    localparam logic [1:0]  MASK_RST       = 2'h1;
    // pins idle: bus line, strobe and gate pulled high, data low
    localparam logic [11:0] SYNC_RST       = 12'he00;

    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] din_hold;
        logic       strb_d;
        logic       pol;
        logic       en;
        logic [7:0] rdata;
    } sdio_top_state_type;

    localparam sdio_top_state_type TOP_RST = '{
        dout: DOUT_RST, din_hold: 8'h00, strb_d: 1'h1,
        pol: POL_RST, en: EN_RST, rdata: 8'h00};

    typedef struct packed {
        logic       pass_d;
        logic [1:0] status;
        logic [1:0] mask;
    } sdio_irq_state_type;

    localparam sdio_irq_state_type IRQ_RST = '{
        pass_d: 1'h0, status: STAT_RST, mask: MASK_RST};

endpackage : sdio_pkg
`default_nettype wire

/* File: hdl/sdio_irq_if.sv */
// signals between the top and the interrupt qualifier
`timescale 1ns/1ps
`default_nettype none
interface sdio_irq_if;
    logic       irq_in;
    logic       gate_n;
    logic       pol;
    logic       en;
    logic       latch_evt;
    logic       mask_wr;
    logic [1:0] clr;
    logic [1:0] wdata;
    logic [1:0] status;
    logic [1:0] mask;
    logic       user_evt;
    logic       irq;

    modport ctl (output irq_in, gate_n, pol, en, latch_evt, mask_wr, clr, wdata,
                 input status, mask, user_evt, irq);
    modport qual (input irq_in, gate_n, pol, en, latch_evt, mask_wr, clr, wdata,
                  output status, mask, user_evt, irq);
endinterface : sdio_irq_if
`default_nettype wire

/* File: hdl/sdio_sync.sv */
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module sdio_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sdio_sync_state_type;

    sdio_sync_state_type st;
    sdio_sync_state_type next_st;

    // first stage feeds only the second
    always_comb begin
        next_st.s1 = d_i;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign q_o = st.s2;
endmodule : sdio_sync
`default_nettype wire

/* File: hdl/sdio_irq.sv */
// user interrupt qualification, sticky status and mask
`timescale 1ns/1ps
`default_nettype none
module sdio_irq (
    input  wire logic clk_i,
    input  wire logic rst_i,
    sdio_irq_if.qual  b
);
    import sdio_pkg::*;

    sdio_irq_state_type st;
    sdio_irq_state_type next_st;
    logic               active;
    logic               pass;
    logic [1:0]         set;

    always_comb begin
        active = b.pol ? b.irq_in : ~b.irq_in;
        pass   = active & b.en & ~b.gate_n;
        b.user_evt = pass & ~st.pass_d;
        set = 2'h0;
        set[STAT_USER_BIT]  = b.user_evt;
        set[STAT_LATCH_BIT] = b.latch_evt;
        next_st        = st;
        next_st.pass_d = pass;
        // set wins over a same-cycle write-one clear
        next_st.status = (st.status & ~b.clr) | set;
        if (b.mask_wr) begin
            next_st.mask = b.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= IRQ_RST;
        end else begin
            st <= next_st;
        end
    end

    assign b.status = st.status;
    assign b.mask   = st.mask;
    assign b.irq    = |(st.status & st.mask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    user_evt_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        b.user_evt |=> st.status[STAT_USER_BIT])
        else $error("user event did not set status");

    gate_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (b.gate_n || !b.en) |-> !b.user_evt)
        else $error("interrupt passed while gated");

    pol_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!b.pol && b.en && !b.gate_n && $fell(b.irq_in) && !st.pass_d)
        |-> b.user_evt)
        else $error("active-low input not recognised");

    user_evt_c: cover property (@(posedge clk_i) disable iff (rst_i) b.user_evt);
endmodule : sdio_irq
`default_nettype wire

/* File: hdl/sdio_top.sv */
// strobed digital i/o banks with a qualified user interrupt
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sdio_top (
    input  wire logic                        MCLK_I,
    input  wire logic                        SYS_RST_I,
    input  wire logic [sdio_pkg::ADDR_W-1:0] REG_ADDR_I,
    input  wire logic [sdio_pkg::DATA_W-1:0] REG_WDATA_I,
    input  wire logic                        REG_WR_I,
    input  wire logic                        REG_RD_I,
    output logic      [sdio_pkg::DATA_W-1:0] REG_RDATA_O,
    output logic      [sdio_pkg::DATA_W-1:0] DOUT_O,
    input  wire logic [sdio_pkg::DATA_W-1:0] DIN_I,
    input  wire logic                        DIN_STROBE_N_I,
    input  wire logic                        IRQ_IN_I,
    input  wire logic                        IRQ_ENABLE_N_I,
    input  wire logic                        INTA_N_I,
    output logic                             INTA_N_O,
    output logic                             INTA_OE_N_O,
    output logic                             IRQ_O
);
    import sdio_pkg::*;

    // ------------------------------------------------------------
    // state and wires
    // ------------------------------------------------------------
    sdio_top_state_type st;
    sdio_top_state_type next_st;

    logic [SYNC_W-1:0]  sync_q;
    logic [DATA_W-1:0]  din_s;
    logic               strb_n_s;
    logic               gate_n_s;
    logic               irq_in_s;
    logic               inta_n_s;
    logic               wr_dout;
    logic               wr_ctrl;
    logic               wr_stat;
    logic               wr_mask;
    logic [DATA_W-1:0]  rd_mux;

    sdio_irq_if irq_bus ();

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // data and strobe share one synchroniser so they stay aligned;
    // a strobe low for under one clock may be missed at this rate
    sdio_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk_i (MCLK_I),
        .rst_i (SYS_RST_I),
        .d_i   ({INTA_N_I, DIN_STROBE_N_I, IRQ_ENABLE_N_I, IRQ_IN_I, DIN_I}),
        .q_o   (sync_q)
    );

    assign din_s    = sync_q[DATA_W-1:0];
    assign irq_in_s = sync_q[8];
    assign gate_n_s = sync_q[9];
    assign strb_n_s = sync_q[10];
    assign inta_n_s = sync_q[11];

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    // single-word programmed access only, no burst path
    assign wr_dout = REG_WR_I && (REG_ADDR_I == ADDR_DOUT);
    assign wr_ctrl = REG_WR_I && (REG_ADDR_I == ADDR_CTRL);
    assign wr_stat = REG_WR_I && (REG_ADDR_I == ADDR_STAT);
    assign wr_mask = REG_WR_I && (REG_ADDR_I == ADDR_MASK);

    always_comb begin
        rd_mux = 8'h00;
        unique case (REG_ADDR_I)
            ADDR_DOUT: begin
                rd_mux = st.dout;
            end
            ADDR_DIN: begin
                rd_mux = st.din_hold;
            end
            ADDR_CTRL: begin
                rd_mux[CTRL_POL_BIT] = st.pol;
                rd_mux[CTRL_EN_BIT]  = st.en;
            end
            ADDR_STAT: begin
                rd_mux[STAT_W-1:0] = irq_bus.status;
            end
            ADDR_MASK: begin
                rd_mux[STAT_W-1:0] = irq_bus.mask;
            end
            ADDR_PINS: begin
                rd_mux[3:0] = {inta_n_s, irq_in_s, gate_n_s, strb_n_s};
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // transparent while the strobe is low, frozen at its release
        if (!strb_n_s) begin
            next_st.din_hold = din_s;
        end
        next_st.strb_d = strb_n_s;
        if (wr_dout) begin
            next_st.dout = REG_WDATA_I;
        end
        if (wr_ctrl) begin
            next_st.pol = REG_WDATA_I[CTRL_POL_BIT];
            next_st.en  = REG_WDATA_I[CTRL_EN_BIT];
        end
        // read data live for exactly the cycle after the strobe
        next_st.rdata = REG_RD_I ? rd_mux : 8'h00;
    end

    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            st <= TOP_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // interrupt path
    // ------------------------------------------------------------
    assign irq_bus.irq_in    = irq_in_s;
    assign irq_bus.gate_n    = gate_n_s;
    assign irq_bus.pol       = st.pol;
    assign irq_bus.en        = st.en;
    assign irq_bus.latch_evt = strb_n_s & ~st.strb_d;
    assign irq_bus.mask_wr   = wr_mask;
    assign irq_bus.clr       = wr_stat ? REG_WDATA_I[STAT_W-1:0] : 2'h0;
    assign irq_bus.wdata     = REG_WDATA_I[STAT_W-1:0];

    sdio_irq u_irq (
        .clk_i (MCLK_I),
        .rst_i (SYS_RST_I),
        .b     (irq_bus.qual)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign REG_RDATA_O = st.rdata;
    assign DOUT_O      = st.dout;
    // open-drain bus line: only ever pulls low
    assign INTA_N_O    = 1'b0;
    assign INTA_OE_N_O = ~irq_bus.irq;
    assign IRQ_O       = irq_bus.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    dout_reset_a: assert property (@(posedge MCLK_I)
        SYS_RST_I |=> (DOUT_O == 8'h00))
        else $error("outputs not low after reset");

    dout_write_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        wr_dout |=> (DOUT_O == $past(REG_WDATA_I)))
        else $error("output bank did not take the write");

    dout_hold_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        !wr_dout |=> $stable(DOUT_O))
        else $error("output bank changed without a write");

    din_follow_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        !strb_n_s |=> (st.din_hold == $past(din_s)))
        else $error("input bank not transparent while strobed");

    din_freeze_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (strb_n_s && st.strb_d) [*2] |-> $stable(st.din_hold))
        else $error("input bank changed with strobe idle");

    din_read_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (REG_RD_I && REG_ADDR_I == ADDR_DIN) |=> (REG_RDATA_O == $past(st.din_hold)))
        else $error("input read returned wrong value");

    cfg_reset_a: assert property (@(posedge MCLK_I)
        SYS_RST_I |=> (st.en == EN_RST && st.pol == POL_RST))
        else $error("interrupt settings wrong after reset");

    inta_drive_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (irq_bus.user_evt && irq_bus.mask[STAT_USER_BIT]) |=> (!INTA_OE_N_O && IRQ_O))
        else $error("user interrupt not forwarded to bus line");

    rd_idle_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        !REG_RD_I |=> (REG_RDATA_O == 8'h00))
        else $error("read data outside read slot");

    // ------------------------------------------------------------
    // readback and interrupt register checks
    // ------------------------------------------------------------
    rdata_reset_a: assert property (@(posedge MCLK_I)
        SYS_RST_I |=> (REG_RDATA_O == 8'h00))
        else $error("read data not cleared by reset");

    irq_reset_a: assert property (@(posedge MCLK_I)
        SYS_RST_I |=> (!IRQ_O && INTA_OE_N_O))
        else $error("interrupt active after reset");

    rd_dout_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (REG_RD_I && REG_ADDR_I == ADDR_DOUT) |=> (REG_RDATA_O == $past(DOUT_O)))
        else $error("output bank read returned wrong value");

    rd_ctrl_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (REG_RD_I && REG_ADDR_I == ADDR_CTRL)
        |=> (REG_RDATA_O == {6'h00, $past(st.en), $past(st.pol)}))
        else $error("control read returned wrong value");

    rd_status_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (REG_RD_I && REG_ADDR_I == ADDR_STAT)
        |=> (REG_RDATA_O == {6'h00, $past(irq_bus.status)}))
        else $error("status read returned wrong value");

    rd_mask_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (REG_RD_I && REG_ADDR_I == ADDR_MASK)
        |=> (REG_RDATA_O == {6'h00, $past(irq_bus.mask)}))
        else $error("mask read returned wrong value");

    rd_pins_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (REG_RD_I && REG_ADDR_I == ADDR_PINS) |=> (REG_RDATA_O[7:4] == 4'h0))
        else $error("pin read upper bits not zero");

    rd_unmapped_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (REG_RD_I && REG_ADDR_I > ADDR_PINS) |=> (REG_RDATA_O == 8'h00))
        else $error("unmapped read returned data");

    ctrl_write_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        wr_ctrl |=> (st.pol == $past(REG_WDATA_I[CTRL_POL_BIT])
            && st.en == $past(REG_WDATA_I[CTRL_EN_BIT])))
        else $error("control write not taken");

    mask_write_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        wr_mask |=> (irq_bus.mask == $past(irq_bus.wdata)))
        else $error("mask write not taken");

    latch_set_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        irq_bus.latch_evt |=> irq_bus.status[STAT_LATCH_BIT])
        else $error("strobe release did not set status");

    status_clear_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (wr_stat && REG_WDATA_I[STAT_USER_BIT] && !irq_bus.user_evt)
        |=> !irq_bus.status[STAT_USER_BIT])
        else $error("user status not cleared by write");

    dout_wr_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) wr_dout);
    latch_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        irq_bus.latch_evt);
    inta_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) $fell(INTA_OE_N_O));
    din_rd_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        REG_RD_I && REG_ADDR_I == ADDR_DIN);

endmodule : sdio_top
`default_nettype wire

/* File: verif/sdio_host_model.sv */
// host-side model: register bus master and the pulled-up shared interrupt wire
`timescale 1ns/1ps
`default_nettype none
module sdio_host_model (
    input  wire logic       clk_i,
    input  wire logic       inta_n_i,
    input  wire logic       inta_oe_n_i,
    output logic      [2:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic            inta_wire_o
);
    logic [7:0] exp_q[$];

    // ------------------------------------------------------------
    // bus wire and single-word accesses
    // ------------------------------------------------------------
    // line is pulled up whenever no board pulls it low
    assign inta_wire_o = inta_oe_n_i ? 1'b1 : inta_n_i;

    initial begin
        addr_o  = 3'h0;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // single words only; each access holds its strobe for one clock
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
    endtask : wr

    // expected word is noted as the request goes out
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_o   <= 1'b0;
    endtask : rd
endmodule : sdio_host_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the strobed digital i/o block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sdio_pkg::*;
    logic       clk = 1'b0;
    logic       rst;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [7:0] dout;
    logic [7:0] din;
    logic       din_strobe_n;
    logic       irq_in;
    logic       irq_enable_n;
    logic       inta_n;
    logic       inta_oe_n;
    logic       inta_wire;
    logic       irq;
    logic       rd_q = 1'b0;
    logic [7:0] d;
    int         seed;
    int         err_count;
    int         n_tests;
    int         cycles = 0;

    sdio_top u_dut (.MCLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .DOUT_O(dout), .DIN_I(din),
        .DIN_STROBE_N_I(din_strobe_n), .IRQ_IN_I(irq_in), .IRQ_ENABLE_N_I(irq_enable_n),
        .INTA_N_I(inta_wire), .INTA_N_O(inta_n), .INTA_OE_N_O(inta_oe_n), .IRQ_O(irq));
    sdio_host_model u_host (.clk_i(clk), .inta_n_i(inta_n), .inta_oe_n_i(inta_oe_n),
        .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .inta_wire_o(inta_wire));

    // ------------------------------------------------------------
    // clock, timeout, checking
    // ------------------------------------------------------------
    always #4 clk = ~clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        // a read whose data never came back counts as a mismatch
        if (u_host.exp_q.size() != 0) begin
            err_count++;
        end
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    always @(posedge clk) begin
        rd_q <= rd;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end

    // read data stands only in the cycle after the strobe
    always @(negedge clk) begin
        if (rd_q === 1'b1) begin
            if (u_host.exp_q.size() == 0) begin
                err_count++;
                $display("unexpected read at %0t got %h exp %h", $time, rdata, 8'hxx);
            end else begin
                chk(rdata, u_host.exp_q.pop_front());
            end
        end
    end

    task automatic irq_chk(input logic e);
        @(negedge clk);
        chk({7'h0, irq}, {7'h0, e});
        chk({7'h0, inta_wire}, {7'h0, ~e});
    endtask : irq_chk

    task automatic toggle_irq();
        @(posedge clk);
        irq_in <= ~irq_in;
        repeat (8) @(posedge clk);
    endtask : toggle_irq

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 3480;
        err_count = 0;
        n_tests = 0;
        rst = 1'b1;
        din = 8'h00;
        din_strobe_n = 1'b1;
        irq_in = 1'b1;
        irq_enable_n = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(dout, 8'h00);
        irq_chk(1'b0);
        u_host.rd(ADDR_CTRL, 8'h02);
        u_host.rd(ADDR_MASK, 8'h01);
        u_host.rd(ADDR_STAT, 8'h00);
        u_host.rd(ADDR_PINS, 8'h0f);
        u_host.rd(3'h6, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            u_host.wr(ADDR_DOUT, d);
            u_host.wr(ADDR_DIN, ~d);
            @(negedge clk);
            chk(dout, d);
            u_host.rd(ADDR_DOUT, d);
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(dout, 8'h00);
        // input bank: data moves away after release and must not show
        d = 8'($random(seed));
        @(posedge clk);
        din <= d;
        din_strobe_n <= 1'b0;
        repeat (4) @(posedge clk);
        din_strobe_n <= 1'b1;
        repeat (4) @(posedge clk);
        din <= ~d;
        repeat (4) @(posedge clk);
        u_host.rd(ADDR_DIN, d);
        u_host.rd(ADDR_STAT, 8'h02);
        u_host.wr(ADDR_MASK, 8'h02);
        irq_chk(1'b1);
        u_host.wr(ADDR_STAT, 8'h02);
        u_host.rd(ADDR_STAT, 8'h00);
        u_host.wr(ADDR_MASK, 8'h01);
        // user interrupt, active low at first
        @(posedge clk);
        irq_enable_n <= 1'b0;
        repeat (8) @(posedge clk);
        irq_chk(1'b0);
        toggle_irq();
        irq_chk(1'b1);
        u_host.rd(ADDR_PINS, 8'h01);
        u_host.wr(ADDR_STAT, 8'h01);
        irq_chk(1'b0);
        toggle_irq();
        u_host.wr(ADDR_CTRL, 8'h03);
        repeat (8) @(posedge clk);
        irq_chk(1'b1);
        u_host.wr(ADDR_STAT, 8'h01);
        toggle_irq();
        irq_chk(1'b0);
        toggle_irq();
        irq_chk(1'b1);
        u_host.wr(ADDR_STAT, 8'h01);
        u_host.wr(ADDR_CTRL, 8'h01);
        toggle_irq();
        toggle_irq();
        irq_chk(1'b0);
        u_host.wr(ADDR_MASK, 8'h00);
        u_host.wr(ADDR_CTRL, 8'h03);
        repeat (8) @(posedge clk);
        irq_chk(1'b0);
        u_host.rd(ADDR_STAT, 8'h01);
        u_host.wr(ADDR_MASK, 8'h01);
        irq_chk(1'b1);
        u_host.wr(ADDR_STAT, 8'h01);
        @(posedge clk);
        irq_enable_n <= 1'b1;
        toggle_irq();
        toggle_irq();
        irq_chk(1'b0);
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule : testbench
`default_nettype wire
